// ==== cmcp_pkg.sv ====
package cmcp_pkg;

	// Captured control scheme.
	typedef enum logic [1:0] {
		CMCP_SCHEME_TWO_WIRE,
		CMCP_SCHEME_PIN_DIFF,
		CMCP_SCHEME_PIN_SE,
		CMCP_SCHEME_THREE_WIRE
	} cmcp_scheme_type;

	// Levels seen on the four-state configuration input.
	localparam logic [1:0] CMCP_CFG_TIE_LOW = 2'h0;
	localparam logic [1:0] CMCP_CFG_PULL_DOWN = 2'h1;
	localparam logic [1:0] CMCP_CFG_PULL_UP = 2'h2;
	localparam logic [1:0] CMCP_CFG_TIE_HIGH = 2'h3;

	localparam int CMCP_WORD_BITS = 16;
	localparam int CMCP_BYTE_BITS = 8;
	localparam int CMCP_INDEX_BITS = 7;
	localparam int CMCP_BITCNT_BITS = 5;
	localparam logic [4:0] CMCP_WORD_LAST = 5'h0F;
	localparam logic [4:0] CMCP_BYTE_LAST = 5'h07;
	localparam int CMCP_MSB_POS = 15;
	localparam int CMCP_INDEX_POS = 8;

	localparam int CMCP_SAMPLE_BITS = 24;
	localparam int CMCP_ZERO_RUN = 1024;
	localparam int CMCP_ZCNT_BITS = 11;
	localparam logic [10:0] CMCP_ZERO_RUN_CNT = 11'h400;

	localparam logic CMCP_COMBINE_RESET = 1'b0;
	localparam logic CMCP_POLARITY_RESET = 1'b0;

	// Pin-control decoding results.
	localparam logic CMCP_ROLE_SLAVE = 1'b0;
	localparam logic CMCP_ROLE_MASTER = 1'b1;
	localparam logic CMCP_FMT_I2S24 = 1'b0;
	localparam logic CMCP_FMT_LJ24 = 1'b1;
	localparam logic [8:0] CMCP_MASTER_RATIO = 9'h100;
	localparam logic [1:0] CMCP_DEEMP_44K1 = 2'h1;

	// Committed register write.
	typedef struct packed {
		logic valid;
		logic [6:0] index;
		logic [7:0] data;
	} cmcp_write_type;

	// Audio setup decoded from the strap pins.
	typedef struct packed {
		logic adc_master;
		logic dac_master;
		logic [8:0] master_ratio;
		logic adc_format;
		logic dac_format;
		logic deemp_en;
		logic [1:0] deemp_rate;
	} cmcp_audio_type;

endpackage : cmcp_pkg

// ==== cmcp_zero_detect.sv ====
`timescale 1ns/10ps
module cmcp_zero_detect (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Sample stream of one channel.
	input wire logic sample_valid,
	input wire logic [cmcp_pkg::CMCP_SAMPLE_BITS-1:0] sample,
	// Detection result.
	output logic zero
);
	import cmcp_pkg::*;

	typedef struct packed {
		logic [CMCP_ZCNT_BITS-1:0] count;
		logic zero;
	} cmcp_zd_type;

	cmcp_zd_type state_reg;
	cmcp_zd_type state_next;

	always_comb begin
		state_next = state_reg;
		if (sample_valid) begin
			if (sample != '0) begin
				state_next.count = '0;
				state_next.zero = 1'b0;
			end else if (state_reg.count != CMCP_ZERO_RUN_CNT) begin
				state_next.count = state_reg.count + 11'h001;
				if (state_reg.count == CMCP_ZERO_RUN_CNT - 11'h001) begin
					state_next.zero = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign zero = state_reg.zero;

endmodule : cmcp_zero_detect

// ==== cmcp_control.sv ====
// Function
// - Each channel flags zero after 1024 consecutive zero samples.
// - Combine off: per-channel flags; on: both flags show joint zero.
// - Polarity off: flags high on zero; on: flags low on zero.
// - Configuration input picks two-wire, pin diff, pin SE or three-wire.
// - Configuration captured only on the first clock after reset, later changes ignored.
// - Three shared pins get their function from the captured scheme.
// - Role pin low: both slaves; high: ADC master at 256 fs.
// - Format pin low: 24-bit I2S; high: 24-bit left-justified.
// - Emphasis pin high enables 44.1 kHz de-emphasis, low disables.
// - Control port shift clock is asynchronous and is oversampled as data by clk.
// - Host shifts data in on shift clock while select is low.
// - Word: 16 bits MSB first, zero, 7-bit index, 8-bit data.
// - Single write commits on select rising after sixteen clocks.
// - Multiple write appends bytes while select low; select high ends.
`timescale 1ns/10ps
module cmcp_control (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Configuration input, four-state level already resolved.
	input wire logic [1:0] config_level,
	// Shared pins (pin 2, pin 1, pin 27).
	input wire logic shared_pin2,
	input wire logic shared_pin1,
	input wire logic shared_pin27,
	// Audio sample stream into the DAC.
	input wire logic sample_valid,
	input wire logic [cmcp_pkg::CMCP_SAMPLE_BITS-1:0] left_sample,
	input wire logic [cmcp_pkg::CMCP_SAMPLE_BITS-1:0] right_sample,
	// Zero-flag settings from the register file.
	input wire logic zero_flag_combine,
	input wire logic zero_flag_polarity,
	// Scheme and routed pins for the two-wire port.
	output cmcp_pkg::cmcp_scheme_type scheme,
	output logic single_ended_out,
	output logic bus_data_in,
	output logic bus_clock_in,
	output logic bus_address_bit,
	// Pin-control decode.
	output cmcp_pkg::cmcp_audio_type audio_setup,
	// Register writes from the three-wire port.
	output cmcp_pkg::cmcp_write_type reg_write,
	// Zero flags.
	output logic left_zero_flag,
	output logic right_zero_flag
);
	import cmcp_pkg::*;

	// Phase of a three-wire frame.
	typedef enum logic [1:0] {
		CMCP_LINK_IDLE,
		CMCP_LINK_WORD,
		CMCP_LINK_BURST,
		CMCP_LINK_DROP
	} cmcp_link_type;

	typedef struct packed {
		cmcp_scheme_type scheme;
		logic captured;
		logic [1:0] sel_sync;
		logic [1:0] clk_sync;
		logic [1:0] dat_sync;
		logic [1:0] p2_sync;
		logic [1:0] p1_sync;
		logic [1:0] p27_sync;
		logic sel_last;
		logic clk_last;
		logic [CMCP_WORD_BITS-1:0] shift;
		logic [CMCP_BITCNT_BITS-1:0] bit_count;
		cmcp_link_type link;
		logic pending;
		logic [CMCP_INDEX_BITS-1:0] index;
		logic [CMCP_BYTE_BITS-1:0] data;
		cmcp_write_type write;
		cmcp_audio_type audio;
		logic bus_data;
		logic bus_clock;
		logic bus_addr;
		logic left_flag;
		logic right_flag;
	} cmcp_state_type;

	cmcp_state_type state_reg;
	cmcp_state_type state_next;
	logic left_zero;
	logic right_zero;

	function automatic cmcp_scheme_type decode_scheme(input logic [1:0] lvl);
		cmcp_scheme_type s;
		s = CMCP_SCHEME_TWO_WIRE;
		unique case (lvl)
			CMCP_CFG_TIE_LOW: s = CMCP_SCHEME_TWO_WIRE;
			CMCP_CFG_PULL_DOWN: s = CMCP_SCHEME_PIN_DIFF;
			CMCP_CFG_PULL_UP: s = CMCP_SCHEME_PIN_SE;
			CMCP_CFG_TIE_HIGH: s = CMCP_SCHEME_THREE_WIRE;
		endcase
		return s;
	endfunction : decode_scheme

	function automatic logic flag_out(input logic hit, input logic inv);
		return hit ^ inv;
	endfunction : flag_out

	// Two-flop synchroniser step: only the second stage is ever read.
	function automatic logic [1:0] sync_step(input logic [1:0] chain,
		input logic pin);
		return {chain[0], pin};
	endfunction : sync_step

	// Rising edge of a synchronised level against last cycle's copy.
	function automatic logic went_high(input logic now_level,
		input logic last_level);
		return now_level && !last_level;
	endfunction : went_high

	// With combining on, each flag shows the joint condition.
	function automatic logic zero_hit(input logic combine, input logic own,
		input logic joint);
		return combine ? joint : own;
	endfunction : zero_hit

	// Strap decode; the fixed fields are rewritten on every update.
	function automatic cmcp_audio_type decode_pins(input logic role,
		input logic fmt, input logic emph);
		cmcp_audio_type a;
		a = '0;
		a.adc_master = role ? CMCP_ROLE_MASTER : CMCP_ROLE_SLAVE;
		a.dac_master = CMCP_ROLE_SLAVE;
		a.master_ratio = CMCP_MASTER_RATIO;
		a.adc_format = fmt ? CMCP_FMT_LJ24 : CMCP_FMT_I2S24;
		a.dac_format = a.adc_format;
		a.deemp_en = emph;
		a.deemp_rate = CMCP_DEEMP_44K1;
		return a;
	endfunction : decode_pins

	cmcp_zero_detect u_zero_left (
		.clk(clk),
		.rst_n(rst_n),
		.sample_valid(sample_valid),
		.sample(left_sample),
		.zero(left_zero)
	);

	cmcp_zero_detect u_zero_right (
		.clk(clk),
		.rst_n(rst_n),
		.sample_valid(sample_valid),
		.sample(right_sample),
		.zero(right_zero)
	);

	always_comb begin
		logic three_wire;
		logic pin_mode;
		logic sel_n;
		logic sclk;
		logic sdat;
		logic [CMCP_WORD_BITS-1:0] sh;
		logic joint_zero;
		three_wire = 1'b0;
		joint_zero = 1'b0;
		pin_mode = 1'b0;
		sel_n = 1'b1;
		sclk = 1'b0;
		sdat = 1'b0;
		sh = '0;
		state_next = state_reg;
		state_next.write.valid = 1'b0;

		// The strap is caught on the first clock after reset release only.
		if (!state_reg.captured) begin
			state_next.scheme = decode_scheme(config_level);
			state_next.captured = 1'b1;
		end

		// Every shared pin passes two flops before any logic reads it.
		state_next.p2_sync = sync_step(state_reg.p2_sync, shared_pin2);
		state_next.p1_sync = sync_step(state_reg.p1_sync, shared_pin1);
		state_next.p27_sync = sync_step(state_reg.p27_sync, shared_pin27);
		state_next.dat_sync = sync_step(state_reg.dat_sync, shared_pin2);
		state_next.clk_sync = sync_step(state_reg.clk_sync, shared_pin1);
		state_next.sel_sync = sync_step(state_reg.sel_sync, shared_pin27);

		// Outside three-wire select reads high, so pin toggles never shift.
		three_wire = state_reg.captured &&
			state_reg.scheme == CMCP_SCHEME_THREE_WIRE;
		pin_mode = state_reg.captured &&
			(state_reg.scheme == CMCP_SCHEME_PIN_DIFF ||
			state_reg.scheme == CMCP_SCHEME_PIN_SE);
		sel_n = three_wire ? state_reg.sel_sync[1] : 1'b1;
		sclk = state_reg.clk_sync[1];
		sdat = state_reg.dat_sync[1];
		state_next.sel_last = sel_n;
		state_next.clk_last = sclk;

		// Two-wire routing; the protocol itself lives elsewhere.
		if (state_reg.captured &&
			state_reg.scheme == CMCP_SCHEME_TWO_WIRE) begin
			state_next.bus_data = state_reg.p2_sync[1];
			state_next.bus_clock = state_reg.p1_sync[1];
			state_next.bus_addr = state_reg.p27_sync[1];
		end else begin
			state_next.bus_data = 1'b1;
			state_next.bus_clock = 1'b1;
			state_next.bus_addr = 1'b0;
		end

		// Outside the strap schemes the last decode is kept, not cleared.
		if (pin_mode) begin
			state_next.audio = decode_pins(state_reg.p27_sync[1],
				state_reg.p1_sync[1], state_reg.p2_sync[1]);
		end

		// Shift clock is oversampled; 4 ns clock easily resolves 32 ns halves.
		if (sel_n) begin
			// Commit only a whole word or a whole burst byte.
			if (went_high(sel_n, state_reg.sel_last) && state_reg.pending) begin
				state_next.write.valid = 1'b1;
				state_next.write.index = state_reg.index;
				state_next.write.data = state_reg.data;
			end
			state_next.bit_count = '0;
			state_next.link = CMCP_LINK_IDLE;
			state_next.pending = 1'b0;
		end else if (went_high(sclk, state_reg.clk_last)) begin
			sh = {state_reg.shift[CMCP_WORD_BITS-2:0], sdat};
			state_next.shift = sh;
			state_next.bit_count = state_reg.bit_count + 5'h01;
			unique case (state_reg.link)
				CMCP_LINK_IDLE, CMCP_LINK_WORD: begin
					state_next.link = CMCP_LINK_WORD;
					if (state_reg.bit_count == CMCP_WORD_LAST) begin
						state_next.bit_count = '0;
						// A set lead bit spoils the whole frame, bursts too.
						if (sh[CMCP_MSB_POS]) begin
							state_next.link = CMCP_LINK_DROP;
						end else begin
							state_next.index = sh[CMCP_MSB_POS-1:CMCP_INDEX_POS];
							state_next.data = sh[CMCP_BYTE_BITS-1:0];
							state_next.pending = 1'b1;
							state_next.link = CMCP_LINK_BURST;
						end
					end
				end
				CMCP_LINK_BURST: begin
					if (state_reg.bit_count == CMCP_BYTE_LAST) begin
						// Earlier byte is written now, the newest waits.
						state_next.write.valid = state_reg.pending;
						state_next.write.index = state_reg.index;
						state_next.write.data = state_reg.data;
						state_next.index = state_reg.index + 7'h01;
						state_next.data = sh[CMCP_BYTE_BITS-1:0];
						state_next.pending = 1'b1;
						state_next.bit_count = '0;
					end
				end
				CMCP_LINK_DROP: begin
					// Bits of a rejected frame still shift in but never reach a write.
					state_next.bit_count = '0;
				end
			endcase
		end

		// Flags are registered so a settings change never glitches the pins.
		joint_zero = left_zero && right_zero;
		state_next.left_flag = flag_out(zero_hit(zero_flag_combine,
			left_zero, joint_zero), zero_flag_polarity);
		state_next.right_flag = flag_out(zero_hit(zero_flag_combine,
			right_zero, joint_zero), zero_flag_polarity);
	end

	// The shift clock is treated as data here, so the port is fully
	// independent of the audio clocks.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			// Idle link levels are loaded so no false edge follows reset.
			state_reg <= '0;
			state_reg.sel_last <= 1'b1;
			state_reg.sel_sync <= 2'h3;
			state_reg.bus_data <= 1'b1;
			state_reg.bus_clock <= 1'b1;
			state_reg.audio.master_ratio <= CMCP_MASTER_RATIO;
			state_reg.audio.deemp_rate <= CMCP_DEEMP_44K1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign scheme = state_reg.scheme;
	assign single_ended_out = state_reg.scheme == CMCP_SCHEME_PIN_SE;
	assign bus_data_in = state_reg.bus_data;
	assign bus_clock_in = state_reg.bus_clock;
	assign bus_address_bit = state_reg.bus_addr;
	assign audio_setup = state_reg.audio;
	assign reg_write = state_reg.write;
	assign left_zero_flag = state_reg.left_flag;
	assign right_zero_flag = state_reg.right_flag;

endmodule : cmcp_control

// ==== cmcp_control_properties.sv ====
`timescale 1ns/10ps
module cmcp_checker
	import cmcp_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Watched ports.
	input wire logic zero_flag_combine,
	input wire cmcp_pkg::cmcp_scheme_type scheme,
	input wire logic single_ended_out,
	input wire logic bus_data_in,
	input wire logic bus_clock_in,
	input wire logic bus_address_bit,
	input wire cmcp_pkg::cmcp_audio_type audio_setup,
	input wire cmcp_pkg::cmcp_write_type reg_write,
	input wire logic left_zero_flag,
	input wire logic right_zero_flag
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// The past guards let the capture at the first edge after reset land.
	a_scheme_held: assert property (
		$past(rst_n, 2) && $past(rst_n) |-> $stable(scheme))
		else $error("scheme changed after capture");
	a_single_ended: assert property (
		$stable(scheme) |-> single_ended_out == (scheme == CMCP_SCHEME_PIN_SE))
		else $error("single ended output wrong");
	a_bus_idle: assert property (
		$stable(scheme) && scheme != CMCP_SCHEME_TWO_WIRE
		|-> {bus_data_in, bus_clock_in, bus_address_bit} == 3'h6)
		else $error("two wire pins not idle");
	a_write_pulse: assert property (
		reg_write.valid |=> !reg_write.valid)
		else $error("write valid longer than one cycle");
	a_write_scheme: assert property (
		reg_write.valid |-> scheme == CMCP_SCHEME_THREE_WIRE)
		else $error("write outside three wire scheme");
	a_joint_flags: assert property (
		zero_flag_combine && $past(zero_flag_combine)
		|-> left_zero_flag == right_zero_flag)
		else $error("combined flags differ");
	a_audio_hold: assert property (
		$past(rst_n, 2) && $stable(scheme) && (scheme == CMCP_SCHEME_TWO_WIRE
		|| scheme == CMCP_SCHEME_THREE_WIRE) |-> $stable(audio_setup))
		else $error("audio setup moved in serial scheme");
	a_fixed_fields: assert property (
		audio_setup.master_ratio == CMCP_MASTER_RATIO && !audio_setup.dac_master
		&& audio_setup.deemp_rate == CMCP_DEEMP_44K1)
		else $error("fixed audio fields wrong");
	a_format_both: assert property (
		audio_setup.adc_format == audio_setup.dac_format)
		else $error("format differs between converters");
	c_write: cover property (reg_write.valid);
	c_zero: cover property ($rose(left_zero_flag));
	c_pin_se: cover property (scheme == CMCP_SCHEME_PIN_SE);
endmodule : cmcp_checker

bind cmcp_control cmcp_checker i_chk (.clk(clk), .rst_n(rst_n),
	.zero_flag_combine(zero_flag_combine), .scheme(scheme),
	.single_ended_out(single_ended_out), .bus_data_in(bus_data_in),
	.bus_clock_in(bus_clock_in), .bus_address_bit(bus_address_bit),
	.audio_setup(audio_setup), .reg_write(reg_write),
	.left_zero_flag(left_zero_flag), .right_zero_flag(right_zero_flag));

// ==== cmcp_host_model.sv ====
`timescale 1ns/10ps
module cmcp_host_model (
	// Shared pins.
	output logic ctrl_serial_in,
	output logic ctrl_shift_clock,
	output logic ctrl_select_n
);
	initial begin
		ctrl_serial_in = 1'b0;
		ctrl_shift_clock = 1'b0;
		ctrl_select_n = 1'b1;
	end
	// Static levels for the strap and two-wire schemes.
	task automatic set_pins(input logic d, input logic c, input logic s);
		ctrl_serial_in = d;
		ctrl_shift_clock = c;
		ctrl_select_n = s;
	endtask : set_pins
	// Clock stands low outside frames; data changes on the falling edge.
	task automatic frame(input logic [31:0] bits, input int n);
		ctrl_select_n = 1'b0;
		#20;
		for (int i = 0; i < n; i++) begin
			ctrl_serial_in = bits[31 - i];
			#32 ctrl_shift_clock = 1'b1;
			#32 ctrl_shift_clock = 1'b0;
		end
		#20 ctrl_select_n = 1'b1;
		ctrl_serial_in = ~ctrl_serial_in;
		#120;
	endtask : frame
endmodule : cmcp_host_model

// ==== cmcp_control_test.sv ====
`timescale 1ns/10ps
module cmcp_control_test;
	import cmcp_pkg::*;
	logic clk;
	logic rst_n;
	logic [1:0] config_level;
	logic sample_valid;
	logic [23:0] left_sample;
	logic [23:0] right_sample;
	logic zero_flag_combine;
	logic zero_flag_polarity;
	logic pin2;
	logic pin1;
	logic pin27;
	cmcp_scheme_type scheme;
	logic single_ended_out;
	logic bus_data_in;
	logic bus_clock_in;
	logic bus_address_bit;
	cmcp_audio_type audio_setup;
	cmcp_audio_type exp;
	cmcp_write_type reg_write;
	logic left_zero_flag;
	logic right_zero_flag;
	int error_cnt = 0;
	int num_checks = 0;

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	cmcp_host_model i_host (.ctrl_serial_in(pin2), .ctrl_shift_clock(pin1),
		.ctrl_select_n(pin27));
	cmcp_control i_dut (.clk(clk), .rst_n(rst_n), .config_level(config_level),
		.shared_pin2(pin2), .shared_pin1(pin1), .shared_pin27(pin27),
		.sample_valid(sample_valid), .left_sample(left_sample),
		.right_sample(right_sample), .zero_flag_combine(zero_flag_combine),
		.zero_flag_polarity(zero_flag_polarity), .scheme(scheme),
		.single_ended_out(single_ended_out), .bus_data_in(bus_data_in),
		.bus_clock_in(bus_clock_in), .bus_address_bit(bus_address_bit),
		.audio_setup(audio_setup), .reg_write(reg_write),
		.left_zero_flag(left_zero_flag), .right_zero_flag(right_zero_flag));

	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] got);
		num_checks++;
		if (got !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, e, got);
		end
	endtask : chk

	task automatic do_reset(input logic [1:0] lv);
		@(posedge clk);
		rst_n <= 1'b0;
		config_level <= lv;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(negedge clk);
	endtask : do_reset

	task automatic test_schemes();
		cmcp_scheme_type tab[4] = '{CMCP_SCHEME_TWO_WIRE, CMCP_SCHEME_PIN_DIFF,
			CMCP_SCHEME_PIN_SE, CMCP_SCHEME_THREE_WIRE};
		for (int lv = 0; lv < 4; lv++) begin
			do_reset(lv[1:0]);
			chk("scheme", tab[lv], scheme);
			chk("single_ended_out", lv == 2, single_ended_out);
			@(posedge clk);
			config_level <= ~lv[1:0];
			repeat (8) @(negedge clk);
			chk("scheme held", tab[lv], scheme);
		end
	endtask : test_schemes

	task automatic pin_scan(input logic [1:0] lv);
		do_reset(lv);
		for (int k = 0; k < 8; k++) begin
			i_host.set_pins(k[0], k[1], k[2]);
			repeat (8) @(negedge clk);
			chk("bus pins", lv == 0 ? {k[0], k[1], k[2]} : 3'h6,
				{bus_data_in, bus_clock_in, bus_address_bit});
			exp = '{k[2], 1'b0, CMCP_MASTER_RATIO, k[1], k[1], k[0],
				CMCP_DEEMP_44K1};
			if (lv != 0) begin
				chk("audio_setup", exp, audio_setup);
			end
		end
	endtask : pin_scan

	task automatic wait_wr(input logic [14:0] e);
		for (int i = 0; i < 600; i++) begin
			@(negedge clk);
			if (reg_write.valid === 1'b1) begin
				chk("reg_write", e, {reg_write.index, reg_write.data});
				return;
			end
		end
		chk("reg_write wait", 1, 0);
		complete_run();
	endtask : wait_wr

	task automatic no_wr(input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			if (reg_write.valid !== 1'b0) begin
				chk("stray write", 0, 1);
			end
		end
	endtask : no_wr

	task automatic test_spi();
		i_host.set_pins(1'b0, 1'b0, 1'b1);
		do_reset(2'h3);
		fork
			i_host.frame(32'h4012_0000, 16);
			wait_wr(15'h4012);
		join
		fork
			i_host.frame(32'h4012_3400, 24);
			begin
				wait_wr(15'h4012);
				wait_wr(15'h4134);
			end
		join
		fork
			i_host.frame(32'hC012_0000, 16);
			no_wr(330);
		join
		fork
			i_host.frame(32'h4012_0000, 12);
			no_wr(260);
		join
		fork
			i_host.frame(32'h4012_3000, 20);
			begin
				wait_wr(15'h4012);
				no_wr(100);
			end
		join
	endtask : test_spi

	task automatic feed(input int n, input logic [23:0] l, input logic [23:0] r,
		input logic [1:0] e);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			sample_valid <= 1'b1;
			left_sample <= l;
			right_sample <= r;
		end
		@(posedge clk);
		sample_valid <= 1'b0;
		repeat (4) @(negedge clk);
		chk("zero flags", e, {left_zero_flag, right_zero_flag});
	endtask : feed

	task automatic test_zero();
		feed(1023, 24'h0, 24'h1, 2'h0);
		feed(1, 24'h0, 24'h1, 2'h2);
		@(posedge clk);
		zero_flag_combine <= 1'b1;
		feed(0, 24'h0, 24'h1, 2'h0);
		@(posedge clk);
		zero_flag_polarity <= 1'b1;
		feed(0, 24'h0, 24'h1, 2'h3);
		feed(1024, 24'h0, 24'h0, 2'h0);
		@(posedge clk);
		zero_flag_combine <= 1'b0;
		zero_flag_polarity <= 1'b0;
		feed(0, 24'h0, 24'h0, 2'h3);
		feed(1, 24'h80_0000, 24'h0, 2'h1);
		feed(1023, 24'h0, 24'h0, 2'h1);
		feed(1, 24'h0, 24'h0, 2'h3);
	endtask : test_zero

	initial begin
		rst_n = 1'b0;
		config_level = 2'h0;
		sample_valid = 1'b0;
		left_sample = 24'h0;
		right_sample = 24'h0;
		zero_flag_combine = 1'b0;
		zero_flag_polarity = 1'b0;
		test_schemes();
		pin_scan(2'h0);
		pin_scan(2'h1);
		pin_scan(2'h2);
		test_spi();
		test_zero();
		complete_run();
	end
endmodule : cmcp_control_test
